// [pcls_cfg.svh]
// Purpose: named offsets, fields, reset values and timing for the pll and line status bank
// Assumes: included by bare name from the package and the design modules
// Notes: definitions only
`ifndef PCLS_CFG_SVH
`define PCLS_CFG_SVH

// register offsets on the control port
`define PCLS_OFS_PLL1_IN 8'h07
`define PCLS_OFS_PLL1_FB 8'h08
`define PCLS_OFS_PLL2 8'h09
`define PCLS_OFS_PLL_CTRL 8'h0a
`define PCLS_OFS_HOST_REV 8'h0b
`define PCLS_OFS_LINE_STAT 8'h0c
`define PCLS_OFS_IRQ_STAT 8'h20
`define PCLS_OFS_IRQ_MASK 8'h21

// reset values
`define PCLS_RST_PLL1_IN 8'h00
`define PCLS_RST_PLL1_FB 8'h00
`define PCLS_RST_PLL1_FB_MODE2 8'h13
`define PCLS_RST_PLL2 8'h00
`define PCLS_RST_BYTE 8'h00
`define PCLS_RST_NIBBLE 4'h0
`define PCLS_RST_IRQ 3'h0

// serial mode strap that selects the alternate feedback reset
`define PCLS_SERIAL_MODE2 2'h2

// field positions
`define PCLS_PLL2_IN_HI 7
`define PCLS_PLL2_IN_LO 4
`define PCLS_PLL2_FB_HI 3
`define PCLS_PLL2_FB_LO 0
`define PCLS_CRS_BIT 0
`define PCLS_LINK_ERR_BIT 7
`define PCLS_FRAME_LOCK_BIT 6

// interrupt status bits
`define PCLS_IRQ_LINK_ERR 0
`define PCLS_IRQ_LOCK_GAIN 1
`define PCLS_IRQ_LOCK_LOSS 2

// loop current decode exceptions
`define PCLS_LMC_HIGH_EXC 5'h1e
`define PCLS_LCC_HIGH_EXC 4'he
`define PCLS_LMC_LOW_EXC 5'h01
`define PCLS_LCC_LOW_EXC 4'h1

// edges after reset release before the strap is sampled into reset values
`define PCLS_INIT_CYCLES 2'h3

`endif

// [pcls_pkg.sv]
// Purpose: shared types for the pll and line status bank
// Assumes: pcls_cfg.svh supplies the constants
// Notes: types only
`include "pcls_cfg.svh"

package pcls_pkg;
  typedef logic [7:0] pcls_byte_t;
  typedef logic [3:0] pcls_nibble_t;
  typedef logic [4:0] pcls_monitor_t;
  typedef enum logic [1:0] {
    PCLS_INIT_WAIT = 2'b00,
    PCLS_INIT_LOAD = 2'b01,
    PCLS_RUN = 2'b10
  } pcls_init_state_t;
endpackage

// [pcls_lcs_if.sv]
// Purpose: carries the line monitor code and hook state to the loop current decoder
// Assumes: one clock domain
// Notes: code is registered inside the decoder
`timescale 1ns/1ps

interface pcls_lcs_if;
  import pcls_pkg::*;
  pcls_monitor_t monitor;
  logic off_hook;
  pcls_nibble_t code;
  modport dec (input monitor, input off_hook, output code);
  modport user (output monitor, output off_hook, input code);
endinterface

// [pcls_lcs_decode.sv]
// Purpose: loop current code from the five-bit line monitor code
// Assumes: monitor and off_hook come from logic on the same clock
// Notes: one cycle of latency from inputs to code
`timescale 1ns/1ps
`include "pcls_cfg.svh"

module pcls_lcs_decode
  import pcls_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // decoder link
  pcls_lcs_if.dec lcs
);
  pcls_nibble_t next_code;

  always_comb begin
    next_code = lcs.monitor[4:1];
    if (lcs.off_hook) begin
      if (lcs.monitor == `PCLS_LMC_HIGH_EXC) begin
        next_code = `PCLS_LCC_HIGH_EXC;
      end else if (lcs.monitor == `PCLS_LMC_LOW_EXC) begin
        next_code = `PCLS_LCC_LOW_EXC;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lcs.code <= `PCLS_RST_NIBBLE;
    end else begin
      lcs.code <= next_code;
    end
  end
endmodule

// [pcls_regs.sv]
// Purpose: pll divider, clock ratio, revision and line side status register bank
// Assumes: link and monitor inputs are on CORE_CLK; SERIAL_MODE is a pin strap
// Notes: registers sit at their byte offsets; unmapped reads return zero
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "pcls_cfg.svh"

module pcls_regs
  import pcls_pkg::*;
#(
  parameter pcls_nibble_t HOST_DIE_REV = 4'h0 // arbitrary value
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [7:0] RD_DATA,
  // strap
  input wire logic [1:0] SERIAL_MODE,
  // link and line state
  input wire logic LINK_FAIL,
  input wire logic LINK_FRAME_LOCK,
  input wire logic OFF_HOOK,
  input wire logic [4:0] LINE_MONITOR_CODE,
  // pll settings
  output logic [7:0] PLL1_INPUT_DIVIDER,
  output logic [7:0] PLL1_FEEDBACK_DIVIDER,
  output logic [3:0] PLL2_INPUT_DIVIDER,
  output logic [3:0] PLL2_FEEDBACK_DIVIDER,
  output logic CLOCK_RATIO_SELECT,
  // interrupt
  output logic IRQ
);
  logic [1:0] mode_meta;
  logic [1:0] mode_sync;
  logic [1:0] init_cnt;
  pcls_init_state_t init_state;
  pcls_byte_t pll1_input_divider;
  pcls_byte_t pll1_feedback_divider;
  pcls_byte_t pll2_dividers;
  logic clock_ratio_select;
  logic link_error;
  logic lock_q;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] irq_event;
  logic wr_line_stat;
  pcls_byte_t next_rd_data;

  pcls_lcs_if lcs ();

  assign lcs.monitor = LINE_MONITOR_CODE;
  assign lcs.off_hook = OFF_HOOK;

  pcls_lcs_decode u_lcs_decode (
    .clk (CORE_CLK),
    .rst_b (RST_B),
    .lcs (lcs)
  );

  // strap crosses from a pin, so two flops first
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_meta <= 2'h0;
      mode_sync <= 2'h0;
    end else begin
      mode_meta <= SERIAL_MODE;
      mode_sync <= mode_meta;
    end
  end

  // strap is applied once, after the synchroniser has settled
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      init_state <= PCLS_INIT_WAIT;
      init_cnt <= 2'h0;
    end else begin
      case (init_state)
        PCLS_INIT_WAIT: begin
          init_cnt <= init_cnt + 2'h1;
          if (init_cnt == `PCLS_INIT_CYCLES - 2'h1) begin
            init_state <= PCLS_INIT_LOAD;
          end
        end
        PCLS_INIT_LOAD: init_state <= PCLS_RUN;
        PCLS_RUN: init_state <= PCLS_RUN;
        default: init_state <= PCLS_INIT_WAIT;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pll1_input_divider <= `PCLS_RST_PLL1_IN;
    end else if (WR_EN && ADDR == `PCLS_OFS_PLL1_IN) begin
      pll1_input_divider <= WR_DATA;
    end
  end

  // a bus write in the load cycle wins over the strap default
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pll1_feedback_divider <= `PCLS_RST_PLL1_FB;
    end else if (WR_EN && ADDR == `PCLS_OFS_PLL1_FB) begin
      pll1_feedback_divider <= WR_DATA;
    end else if (init_state == PCLS_INIT_LOAD) begin
      pll1_feedback_divider <= (mode_sync == `PCLS_SERIAL_MODE2) ?
        `PCLS_RST_PLL1_FB_MODE2 : `PCLS_RST_PLL1_FB;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pll2_dividers <= `PCLS_RST_PLL2;
    end else if (WR_EN && ADDR == `PCLS_OFS_PLL2) begin
      pll2_dividers <= WR_DATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      clock_ratio_select <= 1'b0;
    end else if (WR_EN && ADDR == `PCLS_OFS_PLL_CTRL) begin
      clock_ratio_select <= WR_DATA[`PCLS_CRS_BIT];
    end
  end

  // link error: a failure in the clearing cycle keeps the flag set
  assign wr_line_stat = WR_EN && ADDR == `PCLS_OFS_LINE_STAT;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      link_error <= 1'b0;
    end else if (LINK_FAIL) begin
      link_error <= 1'b1;
    end else if (wr_line_stat && !WR_DATA[`PCLS_LINK_ERR_BIT]) begin
      link_error <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= LINK_FRAME_LOCK;
    end
  end

  assign irq_event[`PCLS_IRQ_LINK_ERR] = LINK_FAIL && !link_error;
  assign irq_event[`PCLS_IRQ_LOCK_GAIN] = LINK_FRAME_LOCK && !lock_q;
  assign irq_event[`PCLS_IRQ_LOCK_LOSS] = !LINK_FRAME_LOCK && lock_q;

  // read clears, but an event in the same cycle survives
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_status <= `PCLS_RST_IRQ;
    end else if (RD_EN && ADDR == `PCLS_OFS_IRQ_STAT) begin
      irq_status <= irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_mask <= `PCLS_RST_IRQ;
    end else if (WR_EN && ADDR == `PCLS_OFS_IRQ_MASK) begin
      irq_mask <= WR_DATA[2:0];
    end
  end

  always_comb begin
    next_rd_data = `PCLS_RST_BYTE;
    case (ADDR)
      `PCLS_OFS_PLL1_IN: next_rd_data = pll1_input_divider;
      `PCLS_OFS_PLL1_FB: next_rd_data = pll1_feedback_divider;
      `PCLS_OFS_PLL2: next_rd_data = pll2_dividers;
      `PCLS_OFS_PLL_CTRL: next_rd_data[`PCLS_CRS_BIT] = clock_ratio_select;
      `PCLS_OFS_HOST_REV: next_rd_data[3:0] = HOST_DIE_REV;
      `PCLS_OFS_LINE_STAT: begin
        next_rd_data[`PCLS_LINK_ERR_BIT] = link_error;
        next_rd_data[`PCLS_FRAME_LOCK_BIT] = LINK_FRAME_LOCK;
        next_rd_data[3:0] = lcs.code;
      end
      `PCLS_OFS_IRQ_STAT: next_rd_data[2:0] = irq_status;
      `PCLS_OFS_IRQ_MASK: next_rd_data[2:0] = irq_mask;
      default: next_rd_data = `PCLS_RST_BYTE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RD_DATA <= `PCLS_RST_BYTE;
    end else if (RD_EN) begin
      RD_DATA <= next_rd_data;
    end else begin
      RD_DATA <= `PCLS_RST_BYTE;
    end
  end

  assign PLL1_INPUT_DIVIDER = pll1_input_divider;
  assign PLL1_FEEDBACK_DIVIDER = pll1_feedback_divider;
  assign PLL2_INPUT_DIVIDER = pll2_dividers[`PCLS_PLL2_IN_HI:`PCLS_PLL2_IN_LO];
  assign PLL2_FEEDBACK_DIVIDER = pll2_dividers[`PCLS_PLL2_FB_HI:`PCLS_PLL2_FB_LO];
  assign CLOCK_RATIO_SELECT = clock_ratio_select;
  assign IRQ = |(irq_status & irq_mask);
endmodule

// [pcls_regs_monitor.sv]
// Purpose: port checks for the pll and line status bank
// Assumes: one clock, reset async active low
// Notes: bound into pcls_regs below
`timescale 1ns/1ps

module pcls_regs_monitor
  import pcls_pkg::*;
#(
  parameter pcls_nibble_t HOST_DIE_REV = 4'h0
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] RD_DATA,
  // line state
  input wire logic LINK_FAIL,
  input wire logic LINK_FRAME_LOCK,
  input wire logic OFF_HOOK,
  input wire logic [4:0] LINE_MONITOR_CODE,
  // pll settings
  input wire logic [7:0] PLL1_INPUT_DIVIDER,
  input wire logic [7:0] PLL1_FEEDBACK_DIVIDER,
  input wire logic [3:0] PLL2_INPUT_DIVIDER,
  input wire logic [3:0] PLL2_FEEDBACK_DIVIDER,
  input wire logic CLOCK_RATIO_SELECT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  function automatic logic [3:0] lcc(input logic oh, input logic [4:0] m);
    if (oh && m == 5'h1e) return 4'he;
    if (oh && m == 5'h01) return 4'h1;
    return m[4:1];
  endfunction

  pll1_in_a: assert property (WR_EN && ADDR == 8'h07 |=> PLL1_INPUT_DIVIDER == $past(WR_DATA))
    else $error("pll1 input divider not written");
  pll1_fb_a: assert property (WR_EN && ADDR == 8'h08 |=> PLL1_FEEDBACK_DIVIDER == $past(WR_DATA))
    else $error("pll1 feedback divider not written");
  pll2_pair_a: assert property (WR_EN && ADDR == 8'h09 |=>
    {PLL2_INPUT_DIVIDER, PLL2_FEEDBACK_DIVIDER} == $past(WR_DATA)) else $error("pll2 dividers misplaced");
  ratio_sel_a: assert property (WR_EN && ADDR == 8'h0a |=> CLOCK_RATIO_SELECT == $past(WR_DATA[0]))
    else $error("clock ratio select not written");
  ctrl_reserved_a: assert property (RD_EN && ADDR == 8'h0a |=> RD_DATA[7:1] == 7'h00)
    else $error("pll control reserved bits nonzero");
  rev_read_a: assert property (RD_EN && ADDR == 8'h0b |=> RD_DATA == {4'h0, HOST_DIE_REV})
    else $error("revision read wrong");
  lock_live_a: assert property (RD_EN && ADDR == 8'h0c |=> RD_DATA[6] == $past(LINK_FRAME_LOCK))
    else $error("frame lock bit wrong");
  err_set_a: assert property (LINK_FAIL ##1 !WR_EN ##1 (RD_EN && ADDR == 8'h0c) |=> RD_DATA[7])
    else $error("link error not set");
  // decoder is one cycle behind, so inputs must have held across the previous edge
  loop_code_a: assert property (RD_EN && ADDR == 8'h0c && $past(RST_B) && $stable(OFF_HOOK)
    && $stable(LINE_MONITOR_CODE) |=> {RD_DATA[5:4], RD_DATA[3:0]} == {2'b00, lcc($past(OFF_HOOK),
    $past(LINE_MONITOR_CODE))}) else $error("loop current code wrong");
endmodule

bind pcls_regs pcls_regs_monitor #(.HOST_DIE_REV(HOST_DIE_REV)) u_mon (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN),
  .RD_EN(RD_EN), .RD_DATA(RD_DATA), .LINK_FAIL(LINK_FAIL), .LINK_FRAME_LOCK(LINK_FRAME_LOCK),
  .OFF_HOOK(OFF_HOOK), .LINE_MONITOR_CODE(LINE_MONITOR_CODE), .PLL1_INPUT_DIVIDER(PLL1_INPUT_DIVIDER),
  .PLL1_FEEDBACK_DIVIDER(PLL1_FEEDBACK_DIVIDER), .PLL2_INPUT_DIVIDER(PLL2_INPUT_DIVIDER),
  .PLL2_FEEDBACK_DIVIDER(PLL2_FEEDBACK_DIVIDER), .CLOCK_RATIO_SELECT(CLOCK_RATIO_SELECT));

// [tb.sv]
// Purpose: directed register tests for pcls_regs
// Assumes: 25 MHz clock, strap held across reset
// Notes: strap mode 2 first, then mode 0
`timescale 1ns/1ps

module tb;
  import pcls_pkg::*;
  localparam pcls_nibble_t REV = 4'h9; // arbitrary value
  logic clk, rst_b = 1'b0, we = 1'b0, re = 1'b0, lfail = 1'b0, lock = 1'b0, ohk = 1'b0;
  logic crs, irq;
  logic [1:0] smode = 2'h2;
  logic [4:0] lmc = 5'h00;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, n1, m1;
  logic [3:0] n2, m2;
  logic [4:0] codes [5] = '{5'h1e, 5'h01, 5'h1f, 5'h00, 5'h0b};
  int mismatches = 0, samples_checked = 0;

  pcls_regs #(.HOST_DIE_REV(REV)) u_dut (
    .CORE_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WR_DATA(wdat), .WR_EN(we), .RD_EN(re),
    .RD_DATA(rdat), .SERIAL_MODE(smode), .LINK_FAIL(lfail), .LINK_FRAME_LOCK(lock), .OFF_HOOK(ohk),
    .LINE_MONITOR_CODE(lmc), .PLL1_INPUT_DIVIDER(n1), .PLL1_FEEDBACK_DIVIDER(m1),
    .PLL2_INPUT_DIVIDER(n2), .PLL2_FEEDBACK_DIVIDER(m2), .CLOCK_RATIO_SELECT(crs), .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [3:0] lcc(input logic oh, input logic [4:0] m);
    if (oh && m == 5'h1e) return 4'he;
    if (oh && m == 5'h01) return 4'h1;
    return m[4:1];
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdat <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    // outputs launched by this edge settle after it, so step past before any compare
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(rdat, exp);
  endtask

  // strap must hold until the init load, so wait well past it
  task automatic do_reset(input logic [1:0] m);
    rst_b <= 1'b0;
    smode <= m;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic pulse_fail;
    @(posedge clk);
    lfail <= 1'b1;
    @(posedge clk);
    lfail <= 1'b0;
  endtask

  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    do_reset(2'h2);
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h13);
    chk(m1, 8'h13);
    rd(8'h0a, 8'h00);
    rd(8'h0b, {4'h0, REV});
    do_reset(2'h0);
    rd(8'h08, 8'h00);
    $display("reset test done");
    wr(8'h07, 8'ha5);
    chk(n1, 8'ha5);
    wr(8'h08, 8'h3c);
    chk(m1, 8'h3c);
    rd(8'h08, 8'h3c);
    wr(8'h09, 8'h5a);
    chk({n2, m2}, 8'h5a);
    rd(8'h09, 8'h5a);
    wr(8'h0a, 8'hff);
    chk({7'h00, crs}, 8'h01);
    rd(8'h0a, 8'h01);
    wr(8'h0a, 8'h00);
    chk({7'h00, crs}, 8'h00);
    wr(8'h0b, 8'hff);
    rd(8'h0b, {4'h0, REV});
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    $display("write test done");
    @(posedge clk);
    lock <= 1'b1;
    pulse_fail();
    rd(8'h0c, 8'hc0);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'hc0);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'h40);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      ohk <= i[0];
      lmc <= codes[i >> 1];
      rd(8'h0c, {4'h4, lcc(i[0], codes[i >> 1])});
    end
    $display("status test done");
    chk({7'h00, irq}, 8'h00);
    rd(8'h20, 8'h03);
    rd(8'h20, 8'h00);
    wr(8'h21, 8'h07);
    pulse_fail();
    #1 chk({7'h00, irq}, 8'h01);
    rd(8'h20, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(8'h21, 8'h03);
    @(posedge clk);
    lock <= 1'b0;
    @(posedge clk);
    #1 chk({7'h00, irq}, 8'h00);
    wr(8'h21, 8'h04);
    #1 chk({7'h00, irq}, 8'h01);
    rd(8'h21, 8'h04);
    rd(8'h20, 8'h04);
    chk({7'h00, irq}, 8'h00);
    $display("interrupt test done");
    conclude();
  end
endmodule
